// ### cfd_top.sv
`default_nettype none
// Behaviour
// - Code-protect field 0 protects all program memory; 1 leaves it open.
// - Write-protect field 0 blocks program memory writes; 1 allows them.
// - Two-speed 1 starts on fast RC, then switches to selection when ready.
// - PWM key-lock 1 needs key sequence before PWM writes; 0 needs none.
// - Window select 11/10/01/00 gives 24/37.5/50/75 percent of period.
// - Oscillator select decodes to the seven listed sources.
// - Mode 1x disables switching and monitor; 01 switch only; 00 both on.
// - Window-disable 0 selects window mode; fraction applies only there.
module cfd_top
  import cfd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic [CFG_W-1:0]  cfg_word,
  input  wire logic              osc_ready,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [31:0]       bus_wdata,
  input  wire logic              bus_we,
  input  wire logic              bus_re,
  output logic      [31:0]       bus_rdata,
  output logic                   cfg_valid,
  output logic                   code_protect,
  output logic                   write_protect,
  output logic                   pwm_write_allow,
  output logic                   wdt_window_en,
  output logic      [9:0]        wdt_window_permille,
  output logic      [2:0]        active_osc,
  output logic                   osc_switch_done,
  output logic                   clk_switch_en,
  output logic                   fail_safe_en,
  output logic                   osc_sel_reserved
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The held word is read back through one 32-bit register, and the
  // highest field must still fit inside it.
  if (CFG_W > 32 || CFG_W < POS_CSW_MODE + 2) begin : g_bad_cfg_w
    $error("Configuration word width does not suit the field layout.");
  end

  // A wait shorter than the synchroniser would capture its reset value.
  if (CAP_WAIT < 2'h2) begin : g_bad_cap_wait
    $error("Capture wait is shorter than the synchroniser.");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [CFG_W-1:0] cfg_meta;
  logic [CFG_W-1:0] cfg_sync;
  logic             rdy_meta;
  logic             rdy_sync;

  // The stored word and the ready flag come from outside this clock.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_meta <= CFG_RESET;
      cfg_sync <= CFG_RESET;
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      cfg_meta <= cfg_word;
      cfg_sync <= cfg_meta;
      rdy_meta <= osc_ready;
      rdy_sync <= rdy_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Capture at reset release
  // ----------------------------------------------------------------------
  logic [1:0]       cap_cnt;
  logic [CFG_W-1:0] cfg_held;
  logic             cap_now;

  // The word cannot be taken under the asynchronous reset itself, so it
  // is taken once the synchroniser has refilled after the release.
  assign cap_now = !cfg_valid && (cap_cnt == CAP_WAIT);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_cnt <= 2'h0;
    end else if (!cfg_valid && cap_cnt != CAP_WAIT) begin
      cap_cnt <= cap_cnt + 2'h1;
    end
  end

  // Once captured the word is frozen; only a new reset reopens it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_held  <= CFG_RESET;
      cfg_valid <= 1'b0;
    end else if (cap_now) begin
      cfg_held  <= cfg_sync;
      cfg_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Field decoder
  // ----------------------------------------------------------------------
  cfd_dec_if dif ();

  assign dif.word = cfg_held;

  cfd_decode u_decode (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------------
  // Two-speed start-up
  // ----------------------------------------------------------------------
  logic     ready_seen;
  logic     on_fast_rc;
  cfd_osc_t sel_osc;

  assign sel_osc = dif.initial_osc_select;

  // Ready is sticky: a source that drops out later is the fail-safe
  // monitor's business, not a reason to fall back here.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_seen <= 1'b0;
    end else if (cfg_valid && rdy_sync) begin
      ready_seen <= 1'b1;
    end
  end

  // A fast RC selection needs no start-up phase, so it is never held
  // back waiting for a ready that would change nothing.
  assign on_fast_rc = dif.two_speed_startup && !ready_seen
                      && (sel_osc != OSC_FAST_RC);

  // ----------------------------------------------------------------------
  // PWM key sequence
  // ----------------------------------------------------------------------
  logic key_armed;
  logic pwm_unlocked;
  logic key_wr;
  logic key1_hit;
  logic key2_hit;

  assign key_wr   = bus_we && (bus_addr == OFS_PWM_KEY);
  assign key1_hit = key_wr && (bus_wdata[15:0] == PWM_KEY_1);
  assign key2_hit = key_wr && (bus_wdata[15:0] == PWM_KEY_2);

  // The two keys must arrive as back-to-back key writes; any other key
  // write disarms and relocks, while writes elsewhere leave it alone.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_armed    <= 1'b0;
      pwm_unlocked <= 1'b0;
    end else begin
      if (key_wr) begin
        key_armed    <= key1_hit;
        pwm_unlocked <= key_armed && key2_hit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------------
  // Until the word is captured the part is held in its safest state:
  // protected, locked and without clock switching.
  // With two-speed start-up, switch done rises once the fast RC phase is over,
  // and at once when the fast RC itself is the selected source; otherwise it stays low.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_protect        <= 1'b1;
      write_protect       <= 1'b1;
      pwm_write_allow     <= 1'b0;
      wdt_window_en       <= 1'b0;
      wdt_window_permille <= 10'h000;
      active_osc          <= OSC_FAST_RC;
      osc_switch_done     <= 1'b0;
      clk_switch_en       <= 1'b0;
      fail_safe_en        <= 1'b0;
      osc_sel_reserved    <= 1'b0;
    end else if (cfg_valid) begin
      code_protect        <= dif.code_protect;
      write_protect       <= dif.write_protect;
      pwm_write_allow     <= !dif.pwm_key_lock || pwm_unlocked;
      wdt_window_en       <= dif.window_en;
      wdt_window_permille <= dif.window_permille;
      active_osc          <= on_fast_rc ? OSC_FAST_RC : sel_osc;
      osc_switch_done     <= dif.two_speed_startup && !on_fast_rc;
      clk_switch_en       <= dif.clk_switch_en;
      fail_safe_en        <= dif.fail_safe_en;
      osc_sel_reserved    <= dif.osc_sel_reserved;
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] read_mux;

  assign status_word = {24'h0, osc_sel_reserved, fail_safe_en,
                        clk_switch_en, on_fast_rc, ready_seen,
                        pwm_unlocked, key_armed, cfg_valid};

  assign read_mux =
      (bus_addr == OFS_CFG_WORD) ? {{(32-CFG_W){1'b0}}, cfg_held} :
      (bus_addr == OFS_STATUS)   ? status_word :
      (bus_addr == OFS_PWM_KEY)  ? {31'h0, pwm_unlocked} :
                                   32'h0;

  // Read data stands in the cycle after each cycle of the strobe; otherwise it reads zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 32'h0;
    end else begin
      bus_rdata <= bus_re ? read_mux : 32'h0;
    end
  end

endmodule : cfd_top
`default_nettype wire

// ### cfd_pkg.sv
`default_nettype none
package cfd_pkg;

  // ----------------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------------
  localparam int CFG_W          = 12;
  localparam int POS_CODE_PROT  = 0;
  localparam int POS_WRITE_PROT = 1;
  localparam int POS_TWO_SPEED  = 2;
  localparam int POS_PWM_LOCK   = 3;
  localparam int POS_WIN_SEL    = 4;   // Two bits, 5:4.
  localparam int POS_WIN_DIS    = 6;
  localparam int POS_OSC_SEL    = 7;   // Three bits, 9:7.
  localparam int POS_CSW_MODE   = 10;  // Two bits, 11:10.

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_FAST_RC     = 3'b000,
    OSC_DIV_RC_PLL  = 3'b001,
    OSC_PRIMARY     = 3'b010,
    OSC_PRIMARY_PLL = 3'b011,
    OSC_SECONDARY   = 3'b100,
    OSC_LOW_POWER   = 3'b101,
    OSC_RESERVED    = 3'b110,
    OSC_DIV_RC      = 3'b111
  } cfd_osc_t;

  // Watchdog window as per-mille of the watchdog period.
  localparam logic [9:0] WIN_PM_11 = 10'h0f0;  // 240 per mille.
  localparam logic [9:0] WIN_PM_10 = 10'h177;  // 375 per mille.
  localparam logic [9:0] WIN_PM_01 = 10'h1f4;  // 500 per mille.
  localparam logic [9:0] WIN_PM_00 = 10'h2ee;  // 750 per mille.

  // ----------------------------------------------------------------------
  // Register map, byte offsets, and key values
  // ----------------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFS_CFG_WORD = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_PWM_KEY  = 8'h08;
  localparam logic [15:0] PWM_KEY_1   = 16'h00a5;  // Arbitrary value.
  localparam logic [15:0] PWM_KEY_2   = 16'h005a;  // Arbitrary value.

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RESET = '0;
  localparam logic [1:0]       CAP_WAIT  = 2'h2;  // Synchroniser depth.

endpackage : cfd_pkg
`default_nettype wire

// ### cfd_dec_if.sv
`default_nettype none
interface cfd_dec_if;
  import cfd_pkg::*;
  logic [CFG_W-1:0] word;
  logic             code_protect;
  logic             write_protect;
  logic             two_speed_startup;
  logic             pwm_key_lock;
  logic             window_en;
  logic [9:0]       window_permille;
  cfd_osc_t         initial_osc_select;
  logic             osc_sel_reserved;
  logic             clk_switch_en;
  logic             fail_safe_en;

  modport src (output word, input code_protect, write_protect,
               two_speed_startup, pwm_key_lock, window_en,
               window_permille, initial_osc_select, osc_sel_reserved,
               clk_switch_en, fail_safe_en);
  modport dec (input word, output code_protect, write_protect,
               two_speed_startup, pwm_key_lock, window_en,
               window_permille, initial_osc_select, osc_sel_reserved,
               clk_switch_en, fail_safe_en);
endinterface : cfd_dec_if
`default_nettype wire

// ### cfd_decode.sv
`default_nettype none
module cfd_decode
  import cfd_pkg::*;
(
  cfd_dec_if.dec d
);

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  wire [1:0] win_sel  = d.word[POS_WIN_SEL +: 2];
  wire [2:0] osc_raw  = d.word[POS_OSC_SEL +: 3];
  wire [1:0] csw_mode = d.word[POS_CSW_MODE +: 2];

  // Protection fields are active low in the stored word.
  assign d.code_protect      = ~d.word[POS_CODE_PROT];
  assign d.write_protect     = ~d.word[POS_WRITE_PROT];
  assign d.two_speed_startup = d.word[POS_TWO_SPEED];
  assign d.pwm_key_lock      = d.word[POS_PWM_LOCK];

  // Window fraction only means anything in window mode.
  assign d.window_en = ~d.word[POS_WIN_DIS];
  assign d.window_permille =
      !d.window_en       ? 10'h000   :
      (win_sel == 2'b11) ? WIN_PM_11 :
      (win_sel == 2'b10) ? WIN_PM_10 :
      (win_sel == 2'b01) ? WIN_PM_01 : WIN_PM_00;

  // A reserved oscillator code is not trusted; the safe internal fast
  // RC source is used instead so the part still comes up.
  assign d.osc_sel_reserved   = (osc_raw == OSC_RESERVED);
  assign d.initial_osc_select = d.osc_sel_reserved ? OSC_FAST_RC
                                : cfd_osc_t'(osc_raw);

  // Upper bit set disables both; otherwise the low bit kills the monitor.
  assign d.clk_switch_en = ~csw_mode[1];
  assign d.fail_safe_en  = ~csw_mode[1] & ~csw_mode[0];

endmodule : cfd_decode
`default_nettype wire

// ### cfd_top_sva.sv
`default_nettype none
module cfd_top_sva
  import cfd_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic [CFG_W-1:0] cfg_word,
  input wire logic             cfg_valid,
  input wire logic             code_protect,
  input wire logic             write_protect,
  input wire logic             pwm_write_allow,
  input wire logic             wdt_window_en,
  input wire logic [9:0]       wdt_window_permille,
  input wire logic [2:0]       active_osc,
  input wire logic             osc_switch_done,
  input wire logic             clk_switch_en,
  input wire logic             fail_safe_en,
  input wire logic             osc_sel_reserved
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CFG_W-1:0] cap;
  logic             seen;
  logic [9:0]       pm;
  // ----------------------------------------------------------------
  // Reference copy of the captured word
  // ----------------------------------------------------------------
  // Copied one edge after capture, so every check waits for the decode.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 1'b0;
      cap  <= '0;
    end else if (cfg_valid && !seen) begin
      seen <= 1'b1;
      cap  <= cfg_word;
    end
  end
  // Expected window share for the captured select code.
  assign pm = cap[5] ? (cap[4] ? WIN_PM_11 : WIN_PM_10)
                     : (cap[4] ? WIN_PM_01 : WIN_PM_00);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_code_prot_map: assert property (seen |-> code_protect == !cap[0])
    else $error("code protect wrong");
  a_write_prot_map: assert property (seen |-> write_protect == !cap[1])
    else $error("write protect wrong");
  a_window_frac: assert property (seen && !cap[6] |->
    wdt_window_en && wdt_window_permille == pm) else $error("window wrong");
  a_window_off: assert property (seen && cap[6] |->
    !wdt_window_en && wdt_window_permille == 10'h000)
    else $error("window not off");
  a_switch_mode: assert property (seen |-> clk_switch_en == !cap[11]
    && fail_safe_en == (cap[11:10] == 2'b00)) else $error("mode wrong");
  a_reserved_flag: assert property (seen |->
    osc_sel_reserved == (cap[9:7] == 3'b110)) else $error("flag wrong");
  a_direct_start: assert property (seen && !cap[2] |->
    active_osc == cap[9:7]) else $error("direct start wrong");
  a_fast_start: assert property (seen && cap[2] && !osc_switch_done |->
    active_osc == 3'b000) else $error("not on fast rc");
  a_pwm_free: assert property (seen && !cap[3] |-> pwm_write_allow)
    else $error("pwm locked");
  a_outputs_hold: assert property (seen |=>
    $stable({code_protect, write_protect, wdt_window_permille}))
    else $error("outputs moved");
endmodule // cfd_top_sva
bind cfd_top cfd_top_sva u_sva (.core_clk, .arst_n, .cfg_word, .cfg_valid,
  .code_protect, .write_protect, .pwm_write_allow, .wdt_window_en,
  .wdt_window_permille, .active_osc, .osc_switch_done, .clk_switch_en,
  .fail_safe_en, .osc_sel_reserved);
`default_nettype wire

// ### config_fuse_decoder_tb.sv
`default_nettype none
module config_fuse_decoder_tb
  import cfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk, arst_n, osc_ready, bus_we, bus_re;
  logic              cfg_valid, code_protect, write_protect;
  logic              pwm_write_allow, wdt_window_en, osc_switch_done;
  logic              clk_switch_en, fail_safe_en, osc_sel_reserved;
  logic [CFG_W-1:0]  cfg_word, w;
  logic [ADDR_W-1:0] bus_addr;
  logic [31:0]       bus_wdata, bus_rdata, r;
  logic [9:0]        wdt_window_permille;
  logic [2:0]        active_osc;
  int                mismatches, n_compared, i, seed;
  logic [CFG_W-1:0]  corner [5] = '{12'h000, 12'hfff, 12'h10c, 12'haa3,
                                    12'h410};
  cfd_top dut (.core_clk, .arst_n, .cfg_word, .osc_ready, .bus_addr,
    .bus_wdata, .bus_we, .bus_re, .bus_rdata, .cfg_valid, .code_protect,
    .write_protect, .pwm_write_allow, .wdt_window_en, .wdt_window_permille,
    .active_osc, .osc_switch_done, .clk_switch_en, .fail_safe_en,
    .osc_sel_reserved);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Window share in per mille; zero when the window is switched off.
  function automatic logic [9:0] exp_pm(input logic [CFG_W-1:0] v);
    if (v[6]) return 10'h000;
    case (v[5:4])
      2'b11: return 10'h0f0;
      2'b10: return 10'h177;
      2'b01: return 10'h1f4;
      default: return 10'h2ee;
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_re   <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_re <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    bus_we    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= {16'h0000, v};
    @(posedge core_clk);
    bus_we <= 1'b0;
  endtask
  // One reset, decode check, register access, start-up, and a key pass when v[3] is set.
  task automatic run_one(input logic [CFG_W-1:0] v);
    logic [31:0] d;
    int          k;
    @(posedge core_clk);
    arst_n    <= 1'b0;
    osc_ready <= 1'b0;
    cfg_word  <= v;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 check("valid", cfg_valid, 1'b1);
    check("code_prot", code_protect, !v[0]);
    check("write_prot", write_protect, !v[1]);
    check("win_en", wdt_window_en, !v[6]);
    check("win_pm", wdt_window_permille, exp_pm(v));
    check("csw_en", clk_switch_en, !v[11]);
    check("fscm_en", fail_safe_en, v[11:10] == 2'b00);
    check("pwm_allow", pwm_write_allow, !v[3]);
    check("osc", active_osc, v[2] ? 3'b000 : v[9:7]);
    check("reserved", osc_sel_reserved, 1'b0);
    bus_wr(OFS_CFG_WORD, 16'hffff);
    bus_rd(OFS_CFG_WORD, d);
    check("cfg_rd", d, {20'h00000, v});
    bus_rd(8'h30, d);
    check("unmapped", d, 32'h0000_0000);
    // Late word change must not leak into the held decode.
    @(posedge core_clk);
    cfg_word  <= ~v;
    osc_ready <= 1'b1;
    for (k = 0; k < 20 && active_osc !== v[9:7]; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (k == 20) begin
      mismatches++;
      complete_run();
    end
    repeat (2) @(posedge core_clk);
    #1 check("switched", osc_switch_done, v[2]);
    check("held", code_protect, !v[0]);
    if (v[3]) begin
      bus_wr(OFS_PWM_KEY, PWM_KEY_1);
      bus_wr(OFS_PWM_KEY, PWM_KEY_2);
      repeat (2) @(posedge core_clk);
      #1 check("unlock", pwm_write_allow, 1'b1);
      bus_rd(OFS_PWM_KEY, d);
      check("key_rd", d, 32'h0000_0001);
      bus_wr(OFS_PWM_KEY, 16'h1234);
      repeat (2) @(posedge core_clk);
      #1 check("relock", pwm_write_allow, 1'b0);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n    = 1'b0;
    osc_ready = 1'b0;
    cfg_word  = '0;
    bus_addr  = '0;
    bus_wdata = '0;
    bus_we    = 1'b0;
    bus_re    = 1'b0;
    seed      = 32'h7ed6;
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      w = (i < 5) ? corner[i] : r[CFG_W-1:0];
      if (w[9:7] == 3'b110) w[9:7] = 3'b111;
      run_one(w);
      $display("test %0d done word %h", i, w);
    end
    complete_run();
  end
endmodule // config_fuse_decoder_tb
`default_nettype wire
